/* File: sec_cfg_pkg.sv */
// Constants for the secondary-side configuration header register bank
package sec_cfg_pkg;
   // Register byte offsets
   localparam logic [7:0] LAT_HDR_OFFSET   = 8'h4c;
   localparam logic [7:0] MEM_BASE_OFFSET  = 8'h50;
   localparam logic [7:0] IO_BASE_OFFSET   = 8'h54;
   localparam logic [7:0] MEM_XLAT_OFFSET  = 8'he0;
   localparam logic [7:0] MEM_SETUP_OFFSET = 8'he4;
   localparam logic [7:0] IO_SETUP_OFFSET  = 8'hf0;
   localparam logic [7:0] STATUS_OFFSET    = 8'hf4;
   // Field positions
   localparam int LAT_LSB       = 8;
   localparam int MEM_BASE_LSB  = 12;
   localparam int IO_BASE_LSB   = 8;
   localparam int MEM_TYPE_LSB  = 1;
   localparam int MEM_PREF_BIT  = 3;
   localparam int IO_EN_BIT     = 0;
   // Reset values
   localparam logic [7:0]  LAT_RESET_PCI  = 8'h00;
   localparam logic [7:0]  LAT_RESET_PCIX = 8'h40;
   localparam logic [6:0]  HDR_CFG_RESET  = 7'h00;
   localparam logic [31:0] WORD_RESET     = 32'h00000000;
   // Decode width codes
   localparam logic [1:0]  TYPE_32BIT     = 2'h0;
   localparam logic [1:0]  TYPE_64BIT     = 2'h1;
   // AXI responses
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   // Cycles after reset release before the straps are taken
   localparam logic [2:0]  STRAP_SETTLE   = 3'h4;
endpackage

/* File: strap_sync.sv */
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module strap_sync (
   input  wire logic core_clk,  // Core clock
   input  wire logic reset_n,   // Synchronous reset, active low
   input  wire logic pin_in,    // Asynchronous pin
   output logic      level_out  // Filtered level
);
   logic stage1_reg;
   logic stage2_reg;
   logic stage3_reg;

   // Shift chain
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
         stage3_reg <= 1'b0;
      end else begin
         stage1_reg <= pin_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   // Update only on agreement
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         level_out <= 1'b0;
      end else if (stage2_reg == stage3_reg) begin
         level_out <= stage3_reg;
      end
   end
endmodule

/* File: sec_cfg_regs.sv */
// Secondary-side configuration header registers with window decode, AXI4-Lite slave
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
module sec_cfg_regs #(
   parameter int ADDR_W = 8  // AXI address width
) (
   input  wire logic              core_clk,       // Core clock, 250 MHz
   input  wire logic              reset_n,        // Synchronous reset, active low
   input  wire logic              fwd_bridge_pin, // Strap: 1 forward, 0 reverse
   input  wire logic              pcix_mode_pin,  // Strap: 1 PCI-X, 0 PCI
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,   // Write address
   input  wire logic              s_axi_awvalid,  // Write address valid
   output logic                   s_axi_awready,  // Write address ready
   input  wire logic [31:0]       s_axi_wdata,    // Write data
   input  wire logic [3:0]        s_axi_wstrb,    // Write byte strobes
   input  wire logic              s_axi_wvalid,   // Write data valid
   output logic                   s_axi_wready,   // Write data ready
   output logic [1:0]             s_axi_bresp,    // Write response
   output logic                   s_axi_bvalid,   // Write response valid
   input  wire logic              s_axi_bready,   // Write response ready
   input  wire logic [ADDR_W-1:0] s_axi_araddr,   // Read address
   input  wire logic              s_axi_arvalid,  // Read address valid
   output logic                   s_axi_arready,  // Read address ready
   output logic [31:0]            s_axi_rdata,    // Read data
   output logic [1:0]             s_axi_rresp,    // Read response
   output logic                   s_axi_rvalid,   // Read data valid
   input  wire logic              s_axi_rready,   // Read data ready
   input  wire logic [31:0]       probe_addr,     // Secondary bus address to decode
   input  wire logic              probe_mem,      // Probe is a memory access
   input  wire logic              probe_valid,    // Probe strobe
   output logic                   csr_hit,        // Access claimed for own registers
   output logic                   fwd_hit,        // Access claimed for upstream forwarding
   output logic                   io_hit,         // Access claimed in I/O window
   output logic [31:0]            fwd_addr        // Translated upstream address
);
   import sec_cfg_pkg::*;

   // Parameter check
   if (ADDR_W < 8) begin : g_bad_addr_w
      $error("ADDR_W must be at least 8");
   end

   localparam int MEM_W = 32 - MEM_BASE_LSB;
   localparam int IO_W  = 32 - IO_BASE_LSB;

   // Strap and mode state
   logic       fwd_sync;
   logic       pcix_sync;
   logic [2:0] settle_reg;
   logic       strap_done_reg;
   logic       fwd_mode_reg;
   logic       pcix_mode_reg;

   // Configuration state
   logic [7:0]       lat_reg;
   logic [MEM_W-1:0] mem_base_reg;
   logic [MEM_W-1:0] mem_mask_reg;
   logic [MEM_W-1:0] mem_xlat_reg;
   logic [1:0]       mem_type_reg;
   logic             mem_pref_reg;
   logic [IO_W-1:0]  io_base_reg;
   logic             io_en_reg;

   // AXI state
   logic [ADDR_W-1:0] aw_addr_reg;
   logic              aw_held_reg;
   logic [31:0]       w_data_reg;
   logic [3:0]        w_strb_reg;
   logic              w_held_reg;

   logic aw_fire;
   logic w_fire;
   logic ar_fire;
   logic wr_do;
   logic [7:0] wr_off;
   logic [7:0] rd_off;
   logic [31:0] rd_word;
   logic        rd_ok;
   logic        wr_ok;
   logic [MEM_W-1:0] mem_mask_next;
   logic [MEM_W-1:0] mem_base_next;
   logic [IO_W-1:0]  io_mask;
   logic [31:0] wr_word;
   logic [31:0] wr_lanes;

   strap_sync u_fwd_sync (
      .core_clk  (core_clk),
      .reset_n   (reset_n),
      .pin_in    (fwd_bridge_pin),
      .level_out (fwd_sync)
   );

   strap_sync u_pcix_sync (
      .core_clk  (core_clk),
      .reset_n   (reset_n),
      .pin_in    (pcix_mode_pin),
      .level_out (pcix_sync)
   );

   // Strap capture after the synchronisers have settled
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         settle_reg     <= 3'h0;
         strap_done_reg <= 1'b0;
         fwd_mode_reg   <= 1'b0;
         pcix_mode_reg  <= 1'b0;
      end else if (!strap_done_reg) begin
         settle_reg <= settle_reg + 3'h1;
         if (settle_reg == STRAP_SETTLE) begin
            strap_done_reg <= 1'b1;
            fwd_mode_reg   <= fwd_sync;
            pcix_mode_reg  <= pcix_sync;
         end
      end
   end

   // Handshake strobes
   assign aw_fire = s_axi_awvalid & s_axi_awready;
   assign w_fire  = s_axi_wvalid & s_axi_wready;
   assign ar_fire = s_axi_arvalid & s_axi_arready;
   assign wr_do   = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   assign wr_off  = {aw_addr_reg[7:2], 2'b00};
   assign rd_off  = {s_axi_araddr[7:2], 2'b00};
   assign wr_lanes = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   assign wr_word = w_data_reg & wr_lanes;  // Unstrobed lanes read as zero

   // Write address capture
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         aw_held_reg   <= 1'b0;
         aw_addr_reg   <= '0;
         s_axi_awready <= 1'b0;
      end else begin
         if (aw_fire) begin
            aw_addr_reg <= s_axi_awaddr;
         end
         if (aw_held_reg) begin
            aw_held_reg   <= ~wr_do;
            s_axi_awready <= wr_do;
         end else begin
            aw_held_reg   <= aw_fire;
            s_axi_awready <= ~aw_fire;
         end
      end
   end

   // Write data capture
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         w_held_reg   <= 1'b0;
         w_data_reg   <= WORD_RESET;
         w_strb_reg   <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         if (w_fire) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (w_held_reg) begin
            w_held_reg   <= ~wr_do;
            s_axi_wready <= wr_do;
         end else begin
            w_held_reg   <= w_fire;
            s_axi_wready <= ~w_fire;
         end
      end
   end

   // Mapped write offsets
   always_comb begin
      case (wr_off)
         LAT_HDR_OFFSET, MEM_BASE_OFFSET, IO_BASE_OFFSET,
         MEM_XLAT_OFFSET, MEM_SETUP_OFFSET, IO_SETUP_OFFSET,
         STATUS_OFFSET: wr_ok = 1'b1;
         default:       wr_ok = 1'b0;
      endcase
   end

   // Write response
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Latency timer: strap default, then software in forward mode only
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         lat_reg <= LAT_RESET_PCI;
      end else if (!strap_done_reg) begin
         lat_reg <= (settle_reg == STRAP_SETTLE && fwd_sync && pcix_sync) ? LAT_RESET_PCIX : LAT_RESET_PCI;
      end else if (!fwd_mode_reg) begin
         lat_reg <= LAT_RESET_PCI;
      end else if (wr_do && wr_off == LAT_HDR_OFFSET && w_strb_reg[1]) begin
         lat_reg <= w_data_reg[LAT_LSB +: 8];
      end
   end

   // Setup legalisation: ones run down from bit 31, so 4KB to 2GB
   always_comb begin
      mem_mask_next = '0;
      mem_mask_next[MEM_W-1] = wr_word[31];
      for (int i = MEM_W - 2; i >= 0; i--) begin
         mem_mask_next[i] = wr_word[i + MEM_BASE_LSB] & mem_mask_next[i+1];
      end
   end

   // Memory window setup, type and prefetch
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         mem_mask_reg <= '0;
         mem_type_reg <= TYPE_32BIT;
         mem_pref_reg <= 1'b0;
      end else if (wr_do && wr_off == MEM_SETUP_OFFSET) begin
         mem_mask_reg <= mem_mask_next;
         mem_type_reg <= (wr_word[MEM_TYPE_LSB +: 2] == TYPE_64BIT) ?
                         TYPE_64BIT : TYPE_32BIT;
         mem_pref_reg <= wr_word[MEM_PREF_BIT];
      end
   end

   // Base bits follow the setup mask
   assign mem_base_next = (mem_base_reg & ~mem_mask_reg) |
                          (wr_word[31:MEM_BASE_LSB] & mem_mask_reg);

   // Memory window base
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         mem_base_reg <= '0;
      end else if (wr_do && wr_off == MEM_BASE_OFFSET) begin
         mem_base_reg <= (mem_base_reg & ~wr_lanes[31:MEM_BASE_LSB]) |
                         (mem_base_next & wr_lanes[31:MEM_BASE_LSB]);
      end
   end

   // Translated base for forwarding
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         mem_xlat_reg <= '0;
      end else if (wr_do && wr_off == MEM_XLAT_OFFSET) begin
         mem_xlat_reg <= (mem_xlat_reg & ~wr_lanes[31:MEM_BASE_LSB]) | wr_word[31:MEM_BASE_LSB];
      end
   end

   // I/O window enable and base
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         io_en_reg   <= 1'b0;
         io_base_reg <= '0;
      end else begin
         if (wr_do && wr_off == IO_SETUP_OFFSET && w_strb_reg[0]) begin
            io_en_reg <= w_data_reg[IO_EN_BIT];
         end
         if (wr_do && wr_off == IO_BASE_OFFSET && io_en_reg) begin
            io_base_reg <= (io_base_reg & ~wr_lanes[31:IO_BASE_LSB]) | wr_word[31:IO_BASE_LSB];
         end
      end
   end
   assign io_mask = io_en_reg ? '1 : '0;  // All base bits decoded while enabled

   // Read multiplexer; reserved bits are zero
   always_comb begin
      rd_word = WORD_RESET;
      rd_ok   = 1'b1;
      case (rd_off)
         LAT_HDR_OFFSET: begin
            rd_word[LAT_LSB +: 8] = lat_reg;
            rd_word[22:16] = HDR_CFG_RESET;
            rd_word[23]    = 1'b0;
            rd_word[31:24] = 8'h00;
         end
         MEM_BASE_OFFSET: begin
            rd_word[0]                 = 1'b0;
            rd_word[MEM_TYPE_LSB +: 2] = mem_type_reg;
            rd_word[MEM_PREF_BIT]      = mem_pref_reg;
            rd_word[31:MEM_BASE_LSB]   = mem_base_reg & mem_mask_reg;
         end
         IO_BASE_OFFSET: begin
            rd_word[0]              = 1'b1;
            rd_word[31:IO_BASE_LSB] = io_base_reg & io_mask;
         end
         MEM_XLAT_OFFSET: rd_word[31:MEM_BASE_LSB] = mem_xlat_reg;
         MEM_SETUP_OFFSET: begin
            rd_word[MEM_TYPE_LSB +: 2] = mem_type_reg;
            rd_word[MEM_PREF_BIT]      = mem_pref_reg;
            rd_word[31:MEM_BASE_LSB]   = mem_mask_reg;
         end
         IO_SETUP_OFFSET: rd_word[IO_EN_BIT] = io_en_reg;
         STATUS_OFFSET: begin
            rd_word[0] = fwd_mode_reg;
            rd_word[1] = pcix_mode_reg;
            rd_word[2] = strap_done_reg;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   // Read channel
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= WORD_RESET;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         s_axi_arready <= ~(ar_fire | (s_axi_rvalid & ~s_axi_rready));
      end
   end

   // Window compare
   logic mem_match;
   logic io_match;
   logic mem_low_page;
   window_match #(.W(MEM_W)) u_mem_match (
      .addr  (probe_addr[31:MEM_BASE_LSB]),
      .base  (mem_base_reg),
      .mask  (mem_mask_reg),
      .match (mem_match)
   );
   window_match #(.W(IO_W)) u_io_match (
      .addr  (probe_addr[31:IO_BASE_LSB]),
      .base  (io_base_reg),
      .mask  (io_mask),
      .match (io_match)
   );
   // First 4KB page of the window lies at the base itself
   assign mem_low_page = (probe_addr[31:MEM_BASE_LSB] == (mem_base_reg & mem_mask_reg));

   // Registered claim outputs
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         csr_hit  <= 1'b0;
         fwd_hit  <= 1'b0;
         io_hit   <= 1'b0;
         fwd_addr <= WORD_RESET;
      end else begin
         csr_hit <= probe_valid & probe_mem & mem_match & mem_low_page;
         fwd_hit <= probe_valid & probe_mem & mem_match & ~mem_low_page;
         io_hit  <= probe_valid & ~probe_mem & io_match;
         fwd_addr <= {(mem_xlat_reg & mem_mask_reg) |
                      (probe_addr[31:MEM_BASE_LSB] & ~mem_mask_reg),
                      probe_addr[MEM_BASE_LSB-1:0]};
      end
   end
endmodule

/* File: window_match.sv */
// Masked address compare; an all-zero mask disables the window
`timescale 1ns/1ns
module window_match #(
   parameter int W = 20  // Compared address bits
) (
   input  wire logic [W-1:0] addr,  // Upper address bits
   input  wire logic [W-1:0] base,  // Window base bits
   input  wire logic [W-1:0] mask,  // Decoded bits, ones from the top
   output logic              match  // Address inside window
);
   if (W < 1) begin : g_bad_w
      $error("W must be positive");
   end

   // Compare decoded bits only
   assign match = mask[W-1] & (((addr ^ base) & mask) == '0);
endmodule

/* File: cfg_master.sv */
// Configuring master model driving the register bank over AXI4-Lite
`timescale 1ns/1ns
module cfg_master (
   input  wire logic        core_clk,       // Clock
   output logic [7:0]       s_axi_awaddr,   // Write address
   output logic             s_axi_awvalid,  // Write address valid
   input  wire logic        s_axi_awready,  // Write address ready
   output logic [31:0]      s_axi_wdata,    // Write data
   output logic [3:0]       s_axi_wstrb,    // Byte strobes
   output logic             s_axi_wvalid,   // Write data valid
   input  wire logic        s_axi_wready,   // Write data ready
   input  wire logic [1:0]  s_axi_bresp,    // Write response
   input  wire logic        s_axi_bvalid,   // Response valid
   output logic             s_axi_bready,   // Response ready
   output logic [7:0]       s_axi_araddr,   // Read address
   output logic             s_axi_arvalid,  // Read address valid
   input  wire logic        s_axi_arready,  // Read address ready
   input  wire logic [31:0] s_axi_rdata,    // Read data
   input  wire logic [1:0]  s_axi_rresp,    // Read response
   input  wire logic        s_axi_rvalid,   // Read valid
   output logic             s_axi_rready    // Read ready
);
   // Idle bus at time zero
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end
   // One write; each channel released once taken, payload scrambled after
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      logic aw_left, w_left;
      aw_left = 1'b1;
      w_left = 1'b1;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw_left || w_left || !s_axi_bvalid) begin
         @(posedge core_clk);
         if (aw_left && s_axi_awready) begin
            aw_left = 1'b0;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (w_left && s_axi_wready) begin
            w_left = 1'b0;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // One read; rready held until the answer is sampled
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge core_clk);
      while (!s_axi_arready) @(posedge core_clk);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      @(posedge core_clk);
      while (!s_axi_rvalid) @(posedge core_clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule

/* File: sec_cfg_regs_assertions.sv */
// Checker for the secondary configuration register bank ports
`timescale 1ns/1ns
module sec_cfg_regs_checker #(
   parameter int ADDR_W = 8  // AXI address width
) (
   input wire logic              core_clk,       // Clock
   input wire logic              reset_n,        // Reset, active low
   input wire logic [1:0]        s_axi_bresp,    // Write response
   input wire logic              s_axi_bvalid,   // Response valid
   input wire logic              s_axi_bready,   // Response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr,   // Read address
   input wire logic              s_axi_arvalid,  // Read address valid
   input wire logic              s_axi_arready,  // Read address ready
   input wire logic [31:0]       s_axi_rdata,    // Read data
   input wire logic [1:0]        s_axi_rresp,    // Read response
   input wire logic              s_axi_rvalid,   // Read valid
   input wire logic              s_axi_rready,   // Read ready
   input wire logic [31:0]       probe_addr,     // Probe address
   input wire logic              probe_mem,      // Probe is memory
   input wire logic              probe_valid,    // Probe strobe
   input wire logic              csr_hit,        // Own register hit
   input wire logic              fwd_hit,        // Forwarding hit
   input wire logic              io_hit,         // I/O hit
   input wire logic [31:0]       fwd_addr        // Translated address
);
   import sec_cfg_pkg::*;
   logic [7:0] rd_off;  // Offset of the read in flight
   logic       rd_map;  // That offset is a register
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // Remember the word offset of each accepted read
   always_ff @(posedge core_clk) begin
      if (!reset_n)
         rd_off <= 8'h00;
      else if (s_axi_arvalid && s_axi_arready)
         rd_off <= {s_axi_araddr[7:2], 2'h0};
   end
   assign rd_map = rd_off inside {LAT_HDR_OFFSET, MEM_BASE_OFFSET, IO_BASE_OFFSET, MEM_XLAT_OFFSET,
                                  MEM_SETUP_OFFSET, IO_SETUP_OFFSET, STATUS_OFFSET};
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   read_refuse_a: assert property (s_axi_rvalid && !rd_map |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   hdr_zero_a: assert property (s_axi_rvalid && rd_off == LAT_HDR_OFFSET |-> s_axi_rdata[31:16] == 16'h0)
      else $error("header type bits not zero");
   mem_flags_a: assert property (s_axi_rvalid && rd_off == MEM_BASE_OFFSET |->
      s_axi_rdata[11:4] == 8'h0 && !s_axi_rdata[0] && !s_axi_rdata[2]) else $error("memory base flags wrong");
   io_flags_a: assert property (s_axi_rvalid && rd_off == IO_BASE_OFFSET |-> s_axi_rdata[7:0] == 8'h01)
      else $error("io base low byte wrong");
   mem_hit_cause_a: assert property (csr_hit || fwd_hit |-> $past(probe_valid && probe_mem) && !(csr_hit && fwd_hit))
      else $error("memory hit without memory probe");
   io_hit_cause_a: assert property (io_hit |-> $past(probe_valid && !probe_mem))
      else $error("io hit without io probe");
   fwd_low_a: assert property (fwd_hit |-> fwd_addr[11:0] == $past(probe_addr[11:0]))
      else $error("forward offset altered");
   cover property (csr_hit);
   cover property (fwd_hit);
   cover property (io_hit);
   cover property (s_axi_rvalid && !rd_map);
endmodule

/* File: secondary_side_config_header_regs_bench.sv */
// Self-checking bench for the secondary configuration register bank
`timescale 1ns/1ns
module secondary_side_config_header_regs_bench;
   import sec_cfg_pkg::*;
   logic core_clk, reset_n, fwd_bridge_pin, pcix_mode_pin, probe_mem, probe_valid, csr_hit, fwd_hit, io_hit;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, inw, win;
   logic [7:0] s_axi_awaddr, s_axi_araddr, lat;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, ty;
   logic [31:0] s_axi_wdata, s_axi_rdata, probe_addr, fwd_addr, wd, mask, base, xlat, off, addr;
   int seed = 15257;
   int miscompares = 0;
   int check_count = 0;
   int m, i, j, n;
   sec_cfg_regs i_sec_cfg_regs (.*);
   cfg_master i_cfg_master (.*);
   // Clock, 4 ns period
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic [1:0] r;
      i_cfg_master.wr(a, d, s, r);
      check({30'h0, r}, {30'h0, er});
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      i_cfg_master.rd(a, d, r);
      check(d, ed);
      check({30'h0, r}, {30'h0, er});
   endtask
   // One probe cycle, results looked at one edge later
   task automatic probe_chk(input logic [31:0] a, input logic mem, input logic ec, input logic ef, input logic ei,
                            input logic [31:0] ea);
      @(posedge core_clk);
      probe_addr <= a;
      probe_mem <= mem;
      probe_valid <= 1'b1;
      @(posedge core_clk);
      probe_valid <= 1'b0;
      #1;
      check({29'h0, csr_hit, fwd_hit, io_hit}, {29'h0, ec, ef, ei});
      if (ef)
         check(fwd_addr, ea);
   endtask
   // Watchdog
   initial begin
      #80000;
      miscompares++;
      give_verdict();
   end
   // Main sequence
   initial begin
      {reset_n, fwd_bridge_pin, pcix_mode_pin, probe_addr, probe_mem, probe_valid} = '0;
      for (m = 0; m < 3; m++) begin
         @(posedge core_clk);
         fwd_bridge_pin <= (m != 2);
         pcix_mode_pin <= (m == 0);
         reset_n <= 1'b0;
         repeat (6) @(posedge core_clk);
         reset_n <= 1'b1;
         repeat (12) @(posedge core_clk);
         lat = (m == 0) ? LAT_RESET_PCIX : LAT_RESET_PCI;
         rd_chk(LAT_HDR_OFFSET, {16'h0, lat, 8'h0}, RESP_OKAY);
         rd_chk(IO_BASE_OFFSET, 32'h1, RESP_OKAY);
         rd_chk(STATUS_OFFSET, {29'h0, 1'b1, m == 0, m != 2}, RESP_OKAY);
         wd = $random(seed);
         wr_chk(MEM_BASE_OFFSET, wd, 4'hf, RESP_OKAY);
         rd_chk(MEM_BASE_OFFSET, WORD_RESET, RESP_OKAY);
         wr_chk(LAT_HDR_OFFSET, wd, 4'hd, RESP_OKAY);
         rd_chk(LAT_HDR_OFFSET, {16'h0, lat, 8'h0}, RESP_OKAY);
         wr_chk(LAT_HDR_OFFSET, wd, 4'hf, RESP_OKAY);
         if (m != 2)
            lat = wd[15:8];
         rd_chk(LAT_HDR_OFFSET, {16'h0, lat, 8'h0}, RESP_OKAY);
         wr_chk(8'h10, wd, 4'hf, RESP_SLVERR);
         rd_chk(8'h10, 32'h0, RESP_SLVERR);
      end
      // Memory window sizes from 4KB to 2GB, all type codes
      for (i = 0; i < 6; i++) begin
         n = (i == 0) ? 12 : (i == 1) ? 31 : 13 + ({$random(seed)} % 18);
         mask = 32'hffffffff << n;
         ty = i[1:0];
         base = $random(seed);
         xlat = $random(seed);
         wr_chk(MEM_SETUP_OFFSET, mask | {28'h0, i[0], ty, 1'b0}, 4'hf, RESP_OKAY);
         wr_chk(MEM_XLAT_OFFSET, xlat, 4'hf, RESP_OKAY);
         wr_chk(MEM_BASE_OFFSET, base, 4'hf, RESP_OKAY);
         rd_chk(MEM_BASE_OFFSET, (base & mask) | {28'h0, i[0], (ty == TYPE_64BIT) ? TYPE_64BIT : TYPE_32BIT, 1'b0},
                RESP_OKAY);
         for (j = 0; j < 4; j++) begin
            off = (j == 0) ? 32'h0fff : (j == 1) ? 32'h1000 : $random(seed);
            addr = (j == 3) ? off : (base & mask) | (off & ~mask);
            inw = ((addr ^ base) & mask) == 32'h0;
            win = inw && ((addr & ~mask) < 32'h1000);
            probe_chk(addr, 1'b1, win, inw && !win, 1'b0, (xlat & mask) | (addr & ~mask));
         end
      end
      wr_chk(MEM_SETUP_OFFSET, 32'h0, 4'hf, RESP_OKAY);
      probe_chk(base & mask, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0);
      // I/O window enabled, then disabled
      wr_chk(IO_SETUP_OFFSET, 32'h1, 4'hf, RESP_OKAY);
      wd = $random(seed);
      wr_chk(IO_BASE_OFFSET, wd, 4'hf, RESP_OKAY);
      rd_chk(IO_BASE_OFFSET, {wd[31:8], 8'h01}, RESP_OKAY);
      probe_chk({wd[31:8], 8'h5a}, 1'b0, 1'b0, 1'b0, 1'b1, 32'h0);
      probe_chk({wd[31:8] ^ 24'h1, 8'h00}, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
      wr_chk(IO_SETUP_OFFSET, 32'h0, 4'hf, RESP_OKAY);
      probe_chk({wd[31:8], 8'hff}, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
      rd_chk(IO_BASE_OFFSET, 32'h1, RESP_OKAY);
      give_verdict();
   end
endmodule
bind sec_cfg_regs sec_cfg_regs_checker #(.ADDR_W(ADDR_W)) i_sec_cfg_regs_checker (.*);
